// ---- iev_event_config.sv ----
// Notes on behaviour
// - Type zero means unused: event never asserts; type resets to zero.
// - Codes 1-3 watch process value against high, low or both limits.
// - Codes 4-6 deviation from setpoint, 7-9 deviation from final setpoint.
// - Codes 10-12 setpoint limits, codes 13-15 manipulated output limits.
// - Codes 16-19 heater burnout and short faults on sensors one then two.
// - Codes 20-22 take loop diagnosis conditions one to three.
// - Status codes 23,24,25,27,28,29,30 map to their status flags, code 32 to its timer event.
// - Codes 26, 31 and 33 are invalid and give no real condition.
// - Second setting is four decimal digits, rightmost first, reset to zero.
// - Rightmost digit: zero passes condition, one inverts it.
// - Second digit: no standby, standby, or standby re-armed on setpoint change.
// - Third digit: zero continues in ready, one forces off; fourth digit zero.
// - Standby suppresses after power-up until condition goes off then on again.
// - With standby, leaving ready for run re-enters standby, event off.
// - Setting two re-arms standby when setpoint value actually changes.
// - Same value written or group change without new value does not re-arm.
// - In ready, event off if standby on or forced off chosen.
//
// The address map and the Avalon-MM register port were left to the implementer.
module iev_event_config
    import iev_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tick,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [4:0]  pv_high_cond,
    input  wire logic [4:0]  pv_low_cond,
    input  wire logic [4:0]  dev_high_cond,
    input  wire logic [4:0]  dev_low_cond,
    input  wire logic [4:0]  devf_high_cond,
    input  wire logic [4:0]  devf_low_cond,
    input  wire logic [4:0]  sp_high_cond,
    input  wire logic [4:0]  sp_low_cond,
    input  wire logic [4:0]  mv_high_cond,
    input  wire logic [4:0]  mv_low_cond,
    input  wire logic [3:0]  heater_fault,
    input  wire logic [2:0]  loop_diag,
    input  wire logic        alarm_present,
    input  wire logic        ready_mode,
    input  wire logic        manual_mode,
    input  wire logic        auto_tuning_run,
    input  wire logic        sp_ramp_active,
    input  wire logic        direct_action,
    input  wire logic        smart_tuning_run,
    input  wire logic [4:0]  timer_event,
    input  wire logic [15:0] setpoint_value,
    output logic [4:0]       event_out,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [4:0][5:0]  type_sel;
        logic [4:0][11:0] cfg2;
        logic [15:0]      sp_prev;
        logic             ready_prev;
        logic             ack;
        logic [31:0]      rdata;
        logic [4:0]       irq_status;
        logic [4:0]       irq_mask;
        logic [4:0]       ev_prev;
    } iev_regs_type;

    iev_regs_type r_reg;
    iev_regs_type r_next;

    logic [4:0] raw_cond;
    logic [4:0] ev_now;
    logic       req;
    logic       take;
    logic       sp_changed;
    logic       ready_to_run;
    logic [6:0] status_flags;

    // Picks the pre-polarity condition for one event from its type code.
    // Every input is an argument, so a continuous assignment that calls it
    // re-evaluates whenever any of them changes.
    function automatic logic iev_select(input logic [5:0] code, input logic [9:0] lim,
                                        input logic [3:0] htr, input logic [2:0] diag,
                                        input logic [6:0] stat, input logic tmr);
        logic res;
        res = 1'b0;
        unique case (code)
            IEV_T_PV_HI:     res = lim[0];
            IEV_T_PV_LO:     res = lim[1];
            IEV_T_PV_HL:     res = lim[0] | lim[1];
            IEV_T_DEV_HI:    res = lim[2];
            IEV_T_DEV_LO:    res = lim[3];
            IEV_T_DEV_HL:    res = lim[2] | lim[3];
            IEV_T_DEVF_HI:   res = lim[4];
            IEV_T_DEVF_LO:   res = lim[5];
            IEV_T_DEVF_HL:   res = lim[4] | lim[5];
            IEV_T_SP_HI:     res = lim[6];
            IEV_T_SP_LO:     res = lim[7];
            IEV_T_SP_HL:     res = lim[6] | lim[7];
            IEV_T_MV_HI:     res = lim[8];
            IEV_T_MV_LO:     res = lim[9];
            IEV_T_MV_HL:     res = lim[8] | lim[9];
            IEV_T_CT1_BURN:  res = htr[0];
            IEV_T_CT1_SHORT: res = htr[1];
            IEV_T_CT2_BURN:  res = htr[2];
            IEV_T_CT2_SHORT: res = htr[3];
            IEV_T_LOOP1:     res = diag[0];
            IEV_T_LOOP2:     res = diag[1];
            IEV_T_LOOP3:     res = diag[2];
            IEV_T_ALARM:     res = stat[0];
            IEV_T_READY:     res = stat[1];
            IEV_T_MANUAL:    res = stat[2];
            IEV_T_AT:        res = stat[3];
            IEV_T_RAMP:      res = stat[4];
            IEV_T_DIRECT:    res = stat[5];
            IEV_T_ST:        res = stat[6];
            IEV_T_TIMER:     res = tmr;
            // Invalid codes, code zero and anything above the table read as off.
            default:         res = 1'b0;
        endcase
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    // A changed value is the only trigger, so a same-value write or a group
    // switch that keeps the value cannot re-arm standby.
    assign sp_changed   = (setpoint_value != r_reg.sp_prev);
    assign ready_to_run = r_reg.ready_prev & ~ready_mode;
    assign status_flags = {smart_tuning_run, direct_action, sp_ramp_active, auto_tuning_run,
                           manual_mode, ready_mode, alarm_present};

    genvar gi;
    generate
        for (gi = 0; gi < IEV_EVENTS; gi++) begin : g_ev
            assign raw_cond[gi] = iev_select(r_reg.type_sel[gi],
                {mv_low_cond[gi], mv_high_cond[gi], sp_low_cond[gi], sp_high_cond[gi],
                 devf_low_cond[gi], devf_high_cond[gi], dev_low_cond[gi],
                 dev_high_cond[gi], pv_low_cond[gi], pv_high_cond[gi]},
                heater_fault, loop_diag, status_flags, timer_event[gi]);

            iev_qualifier u_qual (
                .clk          (clk),
                .rst          (rst),
                .ce           (ce),
                .tick         (tick),
                .enabled      (r_reg.type_sel[gi] != IEV_TYPE_RST),
                .raw_cond     (raw_cond[gi]),
                .cfg2         (r_reg.cfg2[gi]),
                .ready_mode   (ready_mode),
                .ready_to_run (ready_to_run),
                .sp_changed   (sp_changed),
                .event_out    (ev_now[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////

    // Every access waits exactly one clock-enabled (ce) cycle; read data are registered.
    assign req  = avs_read | avs_write;
    assign take = req & ~r_reg.ack;

    always_comb begin
        r_next            = r_reg;
        r_next.sp_prev    = setpoint_value;
        r_next.ready_prev = ready_mode;
        r_next.ev_prev    = ev_now;
        r_next.ack        = take;
        if (take && avs_read) begin
            r_next.rdata = 32'h0000_0000;
            if (avs_address < IEV_OFS_CFG2_0) begin
                r_next.rdata[5:0] = r_reg.type_sel[avs_address - IEV_OFS_TYPE0];
            end else if (avs_address < IEV_OFS_EVENTS) begin
                r_next.rdata[11:0] = r_reg.cfg2[avs_address - IEV_OFS_CFG2_0];
            end else if (avs_address == IEV_OFS_EVENTS) begin
                r_next.rdata[4:0] = ev_now;
            end else if (avs_address == IEV_OFS_IRQ_ST) begin
                r_next.rdata[4:0] = r_reg.irq_status;
                r_next.irq_status = 5'h00;
            end else if (avs_address == IEV_OFS_IRQ_MSK) begin
                r_next.rdata[4:0] = r_reg.irq_mask;
            end
        end
        if (take && avs_write) begin
            if (avs_address < IEV_OFS_CFG2_0) begin
                r_next.type_sel[avs_address - IEV_OFS_TYPE0] = avs_writedata[5:0];
            end else if (avs_address < IEV_OFS_EVENTS) begin
                // The fourth digit is not stored and always reads zero.
                r_next.cfg2[avs_address - IEV_OFS_CFG2_0] = avs_writedata[11:0];
            end else if (avs_address == IEV_OFS_IRQ_MSK) begin
                r_next.irq_mask = avs_writedata[4:0];
            end
        end
        // Rising event edges are applied after the clear so a new edge wins.
        r_next.irq_status = r_next.irq_status | (ev_now & ~r_reg.ev_prev);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg.type_sel   <= {IEV_EVENTS{IEV_TYPE_RST}};
            r_reg.cfg2       <= {IEV_EVENTS{IEV_CFG2_RST}};
            r_reg.sp_prev    <= 16'h0000;
            r_reg.ready_prev <= 1'b0;
            r_reg.ack        <= 1'b0;
            r_reg.rdata      <= 32'h0000_0000;
            r_reg.irq_status <= 5'h00;
            r_reg.irq_mask   <= IEV_MASK_RST;
            r_reg.ev_prev    <= 5'h00;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign avs_readdata    = r_reg.rdata;
    assign avs_waitrequest = req & ~r_reg.ack;
    assign event_out       = ev_now;
    assign irq             = |(r_reg.irq_status & r_reg.irq_mask);

endmodule

// ---- iev_pkg.sv ----
package iev_pkg;

    localparam int          IEV_EVENTS      = 5;
    localparam int          IEV_TYPE_W      = 6;
    localparam int          IEV_CFG2_W      = 12;
    localparam int          IEV_SP_W        = 16;
    localparam int          IEV_ADDR_W      = 4;

    // Word addresses on the register bus.
    localparam logic [3:0]  IEV_OFS_TYPE0   = 4'h0;
    localparam logic [3:0]  IEV_OFS_CFG2_0  = 4'h5;
    localparam logic [3:0]  IEV_OFS_EVENTS  = 4'hA;
    localparam logic [3:0]  IEV_OFS_IRQ_ST  = 4'hB;
    localparam logic [3:0]  IEV_OFS_IRQ_MSK = 4'hC;

    // Digit positions inside the second configuration setting.
    localparam int          IEV_DIG_POL_LSB = 0;
    localparam int          IEV_DIG_SBY_LSB = 4;
    localparam int          IEV_DIG_RDY_LSB = 8;

    localparam logic [5:0]  IEV_TYPE_RST    = 6'h00;
    localparam logic [11:0] IEV_CFG2_RST    = 12'h000;
    localparam logic [4:0]  IEV_MASK_RST    = 5'h00;

    localparam logic [3:0]  IEV_POL_INVERT  = 4'h1;
    localparam logic [3:0]  IEV_SBY_NONE    = 4'h0;
    localparam logic [3:0]  IEV_SBY_SPCHG   = 4'h2;
    localparam logic [3:0]  IEV_RDY_OFF     = 4'h1;

    typedef enum logic [5:0] {
        IEV_T_NONE      = 6'h00, IEV_T_PV_HI     = 6'h01, IEV_T_PV_LO     = 6'h02,
        IEV_T_PV_HL     = 6'h03, IEV_T_DEV_HI    = 6'h04, IEV_T_DEV_LO    = 6'h05,
        IEV_T_DEV_HL    = 6'h06, IEV_T_DEVF_HI   = 6'h07, IEV_T_DEVF_LO   = 6'h08,
        IEV_T_DEVF_HL   = 6'h09, IEV_T_SP_HI     = 6'h0A, IEV_T_SP_LO     = 6'h0B,
        IEV_T_SP_HL     = 6'h0C, IEV_T_MV_HI     = 6'h0D, IEV_T_MV_LO     = 6'h0E,
        IEV_T_MV_HL     = 6'h0F, IEV_T_CT1_BURN  = 6'h10, IEV_T_CT1_SHORT = 6'h11,
        IEV_T_CT2_BURN  = 6'h12, IEV_T_CT2_SHORT = 6'h13, IEV_T_LOOP1     = 6'h14,
        IEV_T_LOOP2     = 6'h15, IEV_T_LOOP3     = 6'h16, IEV_T_ALARM     = 6'h17,
        IEV_T_READY     = 6'h18, IEV_T_MANUAL    = 6'h19, IEV_T_INV26     = 6'h1A,
        IEV_T_AT        = 6'h1B, IEV_T_RAMP      = 6'h1C, IEV_T_DIRECT    = 6'h1D,
        IEV_T_ST        = 6'h1E, IEV_T_INV31     = 6'h1F, IEV_T_TIMER     = 6'h20,
        IEV_T_INV33     = 6'h21
    } iev_code_type;

endpackage

// ---- iev_qualifier.sv ----
module iev_qualifier
    import iev_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        tick,
    input  wire logic        enabled,
    input  wire logic        raw_cond,
    input  wire logic [11:0] cfg2,
    input  wire logic        ready_mode,
    input  wire logic        ready_to_run,
    input  wire logic        sp_changed,
    output logic             event_out
);

    typedef enum logic {IEV_Q_WAIT_OFF, IEV_Q_LIVE} iev_qstate_type;

    typedef struct packed {
        iev_qstate_type state;
        logic           rearm_pending;
        logic           out;
    } iev_qual_type;

    iev_qual_type q_reg;
    iev_qual_type q_next;

    logic [3:0] dig_pol;
    logic [3:0] dig_sby;
    logic [3:0] dig_rdy;
    logic       sby_en;
    logic       rearm_evt;
    logic       qualified;
    logic       polar;
    logic       live;

    assign dig_pol = cfg2[IEV_DIG_POL_LSB +: 4];
    assign dig_sby = cfg2[IEV_DIG_SBY_LSB +: 4];
    assign dig_rdy = cfg2[IEV_DIG_RDY_LSB +: 4];
    assign sby_en  = (dig_sby != IEV_SBY_NONE);
    // Re-arm sources: leaving READY, and a real setpoint change in setting two.
    assign rearm_evt = ready_to_run | (sp_changed & (dig_sby == IEV_SBY_SPCHG));

    always_comb begin
        q_next = q_reg;
        // Standby acts on the condition before polarity. A re-arm waiting for this
        // tick already counts, so the first tick after leaving READY reads OFF.
        live      = (q_reg.state == IEV_Q_LIVE) & !q_reg.rearm_pending & !rearm_evt;
        qualified = raw_cond & (!sby_en | live);
        polar = qualified ^ (dig_pol == IEV_POL_INVERT);
        if (!enabled) begin
            polar = 1'b0;
        end
        if (ready_mode && (sby_en || (dig_rdy == IEV_RDY_OFF))) begin
            polar = 1'b0;
        end
        // Re-arm requests between ticks are held so none is missed.
        if (rearm_evt) begin
            q_next.rearm_pending = 1'b1;
        end
        if (tick) begin
            q_next.out = polar;
            if (rearm_evt || q_reg.rearm_pending) begin
                q_next.state         = IEV_Q_WAIT_OFF;
                q_next.rearm_pending = 1'b0;
            end else if ((q_reg.state == IEV_Q_WAIT_OFF) && !raw_cond) begin
                q_next.state = IEV_Q_LIVE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= '{state: IEV_Q_WAIT_OFF, rearm_pending: 1'b0, out: 1'b0};
        end else if (ce) begin
            q_reg <= q_next;
        end
    end

    assign event_out = q_reg.out;

endmodule

// ---- iev_event_config_chk.sv ----
module iev_event_config_chk
    import iev_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        tick,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [4:0]  pv_high_cond,
    input wire logic        alarm_present,
    input wire logic        ready_mode,
    input wire logic [15:0] setpoint_value,
    input wire logic [4:0]  event_out,
    input wire logic        irq
);
    // Event 0 settings are mirrored from completed bus writes, one cycle behind the design.
    logic [5:0]  t0_reg;
    logic [11:0] cfg0_reg;
    logic        pend_reg;
    wire         evt = tick && ce;
    wire         wr_done = avs_write && !avs_waitrequest;

    always_ff @(posedge clk) begin
        if (rst) begin
            t0_reg   <= 6'h00;
            cfg0_reg <= 12'h000;
            pend_reg <= 1'b1;
        end else if (ce) begin
            if (wr_done && avs_address == IEV_OFS_TYPE0) t0_reg <= avs_writedata[5:0];
            if (wr_done && avs_address == IEV_OFS_CFG2_0) cfg0_reg <= avs_writedata[11:0];
            if (tick) pend_reg <= 1'b0;
            else if (($fell(ready_mode) && cfg0_reg[7:4] != 4'h0)
                || ($changed(setpoint_value) && cfg0_reg[7:4] == IEV_SBY_SPCHG)) pend_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence req_start;
        (avs_read || avs_write) && !$past(avs_read || avs_write);
    endsequence

    a_bus_one_wait: assert property (req_start |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_rd_unmapped: assert property (
        avs_read && !avs_waitrequest && avs_address >= 4'hD |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_tick_hold: assert property (
        !$past(evt) && !$past(rst) |-> $stable(event_out))
        else $error("event changed without tick");
    a_unused_quiet: assert property (
        $past(evt && t0_reg == IEV_TYPE_RST) |-> !event_out[0])
        else $error("unused event asserted");
    a_pv_polarity: assert property (
        $past(evt && t0_reg == 6'h01 && cfg0_reg[11:1] == 11'h0)
        |-> event_out[0] == $past(pv_high_cond[0] ^ cfg0_reg[0]))
        else $error("process value event wrong");
    a_alarm_flag: assert property (
        $past(evt && t0_reg == 6'h17 && cfg0_reg == 12'h000) |-> event_out[0] == $past(alarm_present))
        else $error("alarm status event wrong");
    a_invalid_code: assert property (
        $past(evt && !ready_mode && (t0_reg == 6'h1A || t0_reg == 6'h1F || t0_reg >= 6'h21))
        |-> event_out[0] == $past(cfg0_reg[3:0] == IEV_POL_INVERT))
        else $error("invalid code not constant");
    a_ready_off: assert property (
        $past(evt && ready_mode && (cfg0_reg[7:4] != 4'h0 || cfg0_reg[11:8] == IEV_RDY_OFF))
        |-> !event_out[0])
        else $error("event on in ready mode");
    a_standby_arm: assert property (
        $past(evt && pend_reg && cfg0_reg[7:4] != 4'h0 && cfg0_reg[3:0] == 4'h0) |-> !event_out[0])
        else $error("standby did not suppress");
    a_irq_clear: assert property (
        avs_read && !avs_waitrequest && avs_address == IEV_OFS_IRQ_ST
        && event_out == $past(event_out, 2) |-> !irq)
        else $error("status read did not clear interrupt");
endmodule

bind iev_event_config iev_event_config_chk u_chk (.clk, .rst, .ce, .tick, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pv_high_cond, .alarm_present,
    .ready_mode, .setpoint_value, .event_out, .irq);

// ---- iev_event_config_bench.sv ----
module iev_event_config_bench import iev_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [68:0] PVH = 69'h1 << 64;
    localparam logic [68:0] RDY = 69'h1 << 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        tick = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [68:0] cv = 69'h0;
    logic [15:0] sp_reg = 16'h0000;
    logic [4:0]  event_out;
    logic        irq;
    logic [31:0] note_q[$];
    int          fails = 0;
    int          n_tests = 0;
    int          b;
    logic [68:0] v;

    always #25 clk = ~clk;

    iev_event_config dut (.clk, .rst, .ce, .tick, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .pv_high_cond(cv[68:64]),
        .pv_low_cond(cv[63:59]), .dev_high_cond(cv[58:54]), .dev_low_cond(cv[53:49]),
        .devf_high_cond(cv[48:44]), .devf_low_cond(cv[43:39]), .sp_high_cond(cv[38:34]),
        .sp_low_cond(cv[33:29]), .mv_high_cond(cv[28:24]), .mv_low_cond(cv[23:19]),
        .heater_fault(cv[18:15]), .loop_diag(cv[14:12]), .alarm_present(cv[11]),
        .ready_mode(cv[10]), .manual_mode(cv[9]), .auto_tuning_run(cv[8]),
        .sp_ramp_active(cv[7]), .direct_action(cv[6]), .smart_tuning_run(cv[5]),
        .timer_event(cv[4:0]), .setpoint_value(sp_reg), .event_out, .irq);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic miss(input string m);
        fails++;
        $display("MISMATCH at %0t: %s", $time, m);
    endtask

    // Request stands until the rising edge that sees waitrequest low, released at that edge.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            miss("bus wait ran out");
            tally_and_finish();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        note_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Conditions settle one cycle before the tick so that re-arm causes precede it.
    task automatic do_tick(input logic [68:0] c, input logic [4:0] e);
        @(posedge clk);
        cv <= c;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        rd(IEV_OFS_EVENTS, {27'h0, e});
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk);
        n_tests++;
        if (irq !== e) miss("irq level");
    endtask

    function automatic int sel_bit(int c);
        if (c >= 1 && c <= 15) return ((c - 1) % 3 == 1) ? 59 - 10 * ((c - 1) / 3) : 64 - 10 * ((c - 1) / 3);
        if (c >= 16 && c <= 22) return (c <= 19) ? c - 1 : c - 8;
        case (c)
            23: return 11;
            24: return 10;
            25: return 9;
            27: return 8;
            28: return 7;
            29: return 6;
            30: return 5;
            32: return 0;
            default: return -1;
        endcase
    endfunction

    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            n_tests++;
            if (note_q.size() == 0 || avs_readdata !== note_q[0]) miss("read data");
            if (note_q.size() != 0) note_q.delete(0);
        end
    end

    initial begin
        b = $urandom(72062);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(4'(a), 32'h0);
        bus(1'b1, IEV_OFS_CFG2_0 + 4'h1, 32'h1211);
        rd(IEV_OFS_CFG2_0 + 4'h1, 32'h211);
        $display("test registers done");
        for (int c = 0; c <= 34; c++) begin
            b = sel_bit(c);
            bus(1'b1, IEV_OFS_TYPE0, 32'(c));
            v = 69'({$urandom, $urandom, $urandom});
            if (b >= 0) v[b] = 1'b1;
            do_tick(v, {4'h0, b >= 0});
            v = '1;
            if (b >= 0) v[b] = 1'b0;
            if (c > 0 && c <= 15 && c % 3 == 0) v[b - 5] = 1'b0;
            do_tick(v, 5'h00);
        end
        $display("test type codes done");
        rd(IEV_OFS_IRQ_ST, 32'h1);
        chk_irq(1'b0);
        bus(1'b1, IEV_OFS_IRQ_MSK, 32'h1F);
        bus(1'b1, IEV_OFS_TYPE0, 32'h1);
        do_tick(PVH, 5'h01);
        chk_irq(1'b1);
        rd(IEV_OFS_IRQ_ST, 32'h1);
        chk_irq(1'b0);
        bus(1'b1, IEV_OFS_IRQ_MSK, 32'h0);
        do_tick(69'h0, 5'h00);
        do_tick(PVH, 5'h01);
        chk_irq(1'b0);
        bus(1'b1, IEV_OFS_EVENTS, 32'h0);
        rd(IEV_OFS_EVENTS, 32'h1);
        bus(1'b1, IEV_OFS_IRQ_MSK, 32'h1);
        chk_irq(1'b1);
        rd(IEV_OFS_IRQ_ST, 32'h1);
        $display("test interrupt done");
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(IEV_OFS_CFG2_0 + 4'h1, 32'h0);
        bus(1'b1, IEV_OFS_TYPE0, 32'h1);
        bus(1'b1, IEV_OFS_CFG2_0, 32'h010);
        do_tick(PVH, 5'h00);
        do_tick(69'h0, 5'h00);
        do_tick(PVH, 5'h01);
        do_tick(PVH | RDY, 5'h00);
        do_tick(PVH, 5'h00);
        do_tick(69'h0, 5'h00);
        do_tick(PVH, 5'h01);
        bus(1'b1, IEV_OFS_CFG2_0, 32'h020);
        @(posedge clk);
        sp_reg <= sp_reg;
        do_tick(PVH, 5'h01);
        @(posedge clk);
        sp_reg <= sp_reg ^ 16'($urandom_range(1, 65535));
        do_tick(PVH, 5'h00);
        $display("test standby done");
        bus(1'b1, IEV_OFS_CFG2_0, 32'h100);
        do_tick(PVH | RDY, 5'h00);
        bus(1'b1, IEV_OFS_CFG2_0, 32'h000);
        do_tick(PVH | RDY, 5'h01);
        bus(1'b1, IEV_OFS_CFG2_0, 32'h001);
        do_tick(PVH, 5'h00);
        do_tick(69'h0, 5'h01);
        bus(1'b1, IEV_OFS_TYPE0, 32'h1A);
        do_tick(69'h0, 5'h01);
        bus(1'b1, IEV_OFS_TYPE0, 32'h0);
        bus(1'b1, IEV_OFS_TYPE0 + 4'h4, 32'h1);
        do_tick(69'h1 << 68, 5'h10);
        @(posedge clk);
        ce <= 1'b0;
        cv <= 69'h0;
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        ce <= 1'b1;
        rd(IEV_OFS_EVENTS, 32'h10);
        $display("test ready and polarity done");
        tally_and_finish();
    end
endmodule
